// ---- src/rmd_pkg.sv ----
package rmd_pkg;

  // ---------------------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ---------------------------------------------------------------------------
  // Index per register; one aligned word each, byte address = 4 * index
  localparam logic [7:0] RMD_IDX_RAM_BASE = 8'h10;
  localparam logic [7:0] RMD_IDX_REG_BASE = 8'h11;
  localparam logic [7:0] RMD_IDX_EE_BASE = 8'h12;
  localparam logic [7:0] RMD_IDX_MISC = 8'h14;
  localparam logic [7:0] RMD_IDX_WAIT_CTRL = 8'h18;
  localparam logic [7:0] RMD_ADDR_RAM_BASE = {RMD_IDX_RAM_BASE[5:0], 2'h0};
  localparam logic [7:0] RMD_ADDR_REG_BASE = {RMD_IDX_REG_BASE[5:0], 2'h0};
  localparam logic [7:0] RMD_ADDR_EE_BASE = {RMD_IDX_EE_BASE[5:0], 2'h0};
  localparam logic [7:0] RMD_ADDR_MISC = {RMD_IDX_MISC[5:0], 2'h0};
  localparam logic [7:0] RMD_ADDR_WAIT_CTRL = {RMD_IDX_WAIT_CTRL[5:0], 2'h0};

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RMD_RST_RAM_BASE = 8'h00;
  localparam logic [7:0] RMD_RST_REG_BASE = 8'h00;
  localparam logic [7:0] RMD_RST_EE_BASE = 8'h01;
  localparam logic [7:0] RMD_RST_MISC_EXP = 8'h0c;
  localparam logic [7:0] RMD_RST_MISC_SC = 8'h0f;
  localparam logic [7:0] RMD_RST_WAIT_CTRL = 8'h00;

  // ---------------------------------------------------------------------------
  // Writable bit masks, field positions
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RMD_MASK_RAM_BASE = 8'hf8;
  localparam logic [7:0] RMD_MASK_REG_BASE = 8'hf8;
  localparam logic [7:0] RMD_MASK_EE_BASE = 8'hf1;
  localparam logic [7:0] RMD_MASK_WAIT_CTRL = 8'h01;
  localparam int RMD_EE_ENABLE_BIT = 0;
  localparam int RMD_SWAP_BIT = 7;
  localparam int RMD_NARROW_BIT = 6;
  localparam int RMD_RF_STR_LSB = 4;
  localparam int RMD_EX_STR_LSB = 2;
  localparam int RMD_SMALL_EN_BIT = 1;
  localparam int RMD_LARGE_EN_BIT = 0;

  // ---------------------------------------------------------------------------
  // Fixed address windows
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RMD_DBG_ROM_LO = 16'hff00;
  localparam logic [15:0] RMD_FLASH_LOW_LO = 16'h1000;
  localparam logic [15:0] RMD_FLASH_SPLIT = 16'h8000;
  localparam logic [15:0] RMD_FLASH_HIGH_LO = 16'h9000;

  // Operating modes as {special_n, b, a}
  localparam logic [2:0] RMD_MODE_SPC_SC = 3'h0;
  localparam logic [2:0] RMD_MODE_SPC_NAR = 3'h1;
  localparam logic [2:0] RMD_MODE_PERIPH = 3'h2;
  localparam logic [2:0] RMD_MODE_SPC_WIDE = 3'h3;
  localparam logic [2:0] RMD_MODE_NRM_SC = 3'h4;
  localparam logic [2:0] RMD_MODE_NRM_NAR = 3'h5;
  localparam logic [2:0] RMD_MODE_NRM_WIDE = 3'h7;

  // One-hot decode targets
  typedef enum logic [6:0] {
    RMD_TGT_NONE = 7'h00,
    RMD_TGT_DBG = 7'h01,
    RMD_TGT_REGS = 7'h02,
    RMD_TGT_RAM = 7'h04,
    RMD_TGT_EE = 7'h08,
    RMD_TGT_SMALL = 7'h10,
    RMD_TGT_LARGE = 7'h20,
    RMD_TGT_EXT = 7'h40
  } rmd_target_t;

endpackage

// ---- src/rmd_decoder.sv ----
// Function
// [RQ1] Base registers write once normal, anytime special
// [RQ2] New mapping takes effect next cycle
// [RQ3] Fixed overlap precedence, one target only
// [RQ4] Unclaimed space is external in expanded
// [RQ5] Register block 512 bytes, 2K aligned
// [RQ6] Register base from bits 15 to 11
// [RQ7] Wait-stop bit gates mapping in wait
// [RQ8] RAM 2K, base bits 15 to 11
// [RQ9] Software moves register block off RAM
// [RQ10] EEPROM 1K, base bits 15 to 12
// [RQ11] EEPROM enable, forced on single-chip
// [RQ12] Flash enables reset by mode
// [RQ13] Swap bit exchanges flash array placement
// [RQ14] Narrow bit gives 8-bit follow region
// [RQ15] Follow region sits above register block
// [RQ16] Follow region stretch 0 to 3
// [RQ17] External stretch 0 to 3, reset 3
// [RQ18] Debug ROM overrides top while active
// [RQ19] E clock held high while stretching
// [RQ20] Unimplemented bits read zero
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module rmd_decoder
  import rmd_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mode and status inputs
  input wire logic [2:0] op_mode,
  input wire logic wait_mode,
  input wire logic background_debug,
  // CPU address side
  input wire logic cpu_valid,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic e_phase_end,
  // Decode outputs
  output logic [6:0] sel_target,
  output logic sel_follow_region,
  output logic bus_narrow,
  output logic [1:0] stretch_cycles,
  output logic e_hold_high,
  output logic map_shutdown
);

  // ---------------------------------------------------------------------------
  // Mode helpers
  // ---------------------------------------------------------------------------
  // Special modes have the top mode bit low;
  // they relax write-once guards and lock wait-stop
  function automatic logic rmd_is_special(input logic [2:0] m);
    return (m[2] == 1'b0);
  endfunction

  // Expanded modes own an external bus;
  // peripheral mode has no on-chip master
  function automatic logic rmd_is_expanded(input logic [2:0] m);
    return (m == RMD_MODE_SPC_NAR) || (m == RMD_MODE_SPC_WIDE) ||
           (m == RMD_MODE_NRM_NAR) || (m == RMD_MODE_NRM_WIDE);
  endfunction

  // Only wide modes may narrow the follow region
  function automatic logic rmd_is_wide(input logic [2:0] m);
    return (m == RMD_MODE_SPC_WIDE) || (m == RMD_MODE_NRM_WIDE);
  endfunction

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [7:0] ram_base_position;
  logic [7:0] register_block_position;
  logic [7:0] eeprom_base_position;
  logic [7:0] misc_mapping_control;
  logic [7:0] wait_control;
  logic ram_written;
  logic reg_written;
  logic ee_written;
  logic misc_written;
  logic misc_loaded;
  logic special;
  logic expanded;
  logic wr_en;
  logic rd_en;


  // ---------------------------------------------------------------------------
  // Mode and strobe decode
  // ---------------------------------------------------------------------------
  assign special = rmd_is_special(op_mode);
  assign expanded = rmd_is_expanded(op_mode);
  // Writes land only at the edge where pready is seen high;
  // a master that overstays its access cannot write twice
  // Zero-wait APB: access completes in the first access cycle
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite && pready;

  // Once-only write permission per register
  function automatic logic rmd_may_write(input logic spc, input logic done);
    return spc || !done;
  endfunction

  // ---------------------------------------------------------------------------
  // Base position registers
  // ---------------------------------------------------------------------------
  // Write-once guards keep stray code from moving the map;
  // special modes skip them so test code can remap freely
  // Written flags stay set for the rest of the reset epoch
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ram_base_position <= RMD_RST_RAM_BASE;
      ram_written <= 1'b0;
    end else if (wr_en && paddr == RMD_ADDR_RAM_BASE && rmd_may_write(special, ram_written)) begin
      ram_base_position <= pwdata[7:0] & RMD_MASK_RAM_BASE; // RQ1 RQ8 RQ20
      ram_written <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      // Registers start at zero and shadow the low RAM bytes
      register_block_position <= RMD_RST_REG_BASE; // RQ5
      reg_written <= 1'b0;
    end else if (wr_en && paddr == RMD_ADDR_REG_BASE && rmd_may_write(special, reg_written)) begin
      register_block_position <= pwdata[7:0] & RMD_MASK_REG_BASE; // RQ1 RQ6 RQ20
      reg_written <= 1'b1;
    end
  end

  // Enable bit is writable anytime; only the base field is once-only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      eeprom_base_position <= RMD_RST_EE_BASE;
      ee_written <= 1'b0;
    end else if (wr_en && paddr == RMD_ADDR_EE_BASE) begin
      eeprom_base_position[RMD_EE_ENABLE_BIT] <= pwdata[RMD_EE_ENABLE_BIT]; // RQ11
      if (rmd_may_write(special, ee_written)) begin
        eeprom_base_position[7:1] <= pwdata[7:1] & RMD_MASK_EE_BASE[7:1]; // RQ1 RQ10 RQ20
        ee_written <= 1'b1;
      end
    end
  end

  // Mode pins are trusted only after release, so the
  // flash enables settle one edge late
  // Mode-dependent reset value is loaded in the first clocked cycle after release
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      misc_mapping_control <= RMD_RST_MISC_EXP; // RQ17
      misc_written <= 1'b0;
      misc_loaded <= 1'b0;
    end else if (!misc_loaded) begin
      misc_mapping_control <= expanded ? RMD_RST_MISC_EXP : RMD_RST_MISC_SC; // RQ12
      misc_loaded <= 1'b1;
    end else if (wr_en && paddr == RMD_ADDR_MISC && rmd_may_write(special, misc_written)) begin
      misc_mapping_control <= pwdata[7:0]; // RQ1 RQ13
      misc_written <= 1'b1;
    end
  end

  // Wait-stop bit: writable anytime in normal modes, never in special
  // Special modes keep mapping alive for debug in wait
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_control <= RMD_RST_WAIT_CTRL;
    end else if (wr_en && paddr == RMD_ADDR_WAIT_CTRL && !special) begin
      wait_control <= pwdata[7:0] & RMD_MASK_WAIT_CTRL; // RQ7 RQ20
    end
  end

  // ---------------------------------------------------------------------------
  // APB read path and answer
  // ---------------------------------------------------------------------------
  logic [7:0] next_rdata;
  logic next_err;

  // Index decode; unmapped offsets error and read zero,
  // so a stray read cannot leak stale state
  always_comb begin
    next_err = 1'b0;
    case (paddr)
      RMD_ADDR_RAM_BASE: next_rdata = ram_base_position;
      RMD_ADDR_REG_BASE: next_rdata = register_block_position;
      RMD_ADDR_EE_BASE: begin
        // EEPROM always visible as enabled in single-chip modes
        next_rdata = eeprom_base_position | (expanded ? 8'h00 : 8'h01); // RQ11
      end
      RMD_ADDR_MISC: next_rdata = misc_mapping_control;
      RMD_ADDR_WAIT_CTRL: next_rdata = wait_control;
      default: begin
        next_rdata = 8'h00;
        next_err = 1'b1;
      end
    endcase
  end

  // pready registered: high in the access cycle, low otherwise
  // Read data is captured at setup, so it stands in access
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && next_err;
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h00_0000, next_rdata};
      end
    end
  end

  // Holding access cycle until pready: writes qualified by pready
  logic unused_rd;
  assign unused_rd = rd_en;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // Per-resource claims, each blind to the others;
  // the chain below settles any overlap
  logic eeprom_on;
  logic hit_dbg;
  logic hit_regs;
  logic hit_follow;
  logic hit_ram;
  logic hit_ee;
  logic hit_small;
  logic hit_large;
  logic swap;
  logic active;
  rmd_target_t next_target;

  assign swap = misc_mapping_control[RMD_SWAP_BIT];
  assign eeprom_on = eeprom_base_position[RMD_EE_ENABLE_BIT] || !expanded; // RQ11
  assign active = cpu_valid && !(wait_mode && wait_control[0]); // RQ7
  // Registered bases are used directly: a write lands one cycle later
  // and the next sampled address sees it; a staging
  // register would push the change out a cycle too far
  assign hit_dbg = background_debug && (cpu_addr >= RMD_DBG_ROM_LO); // RQ18
  // Registers take the low 512 bytes of their 2K window,
  // the follow region the next 512
  assign hit_regs = cpu_addr[15:11] == register_block_position[7:3] &&
                    cpu_addr[10:9] == 2'b00; // RQ5 RQ6
  assign hit_follow = cpu_addr[15:11] == register_block_position[7:3] &&
                      cpu_addr[10:9] == 2'b01; // RQ15
  assign hit_ram = cpu_addr[15:11] == ram_base_position[7:3]; // RQ2 RQ8
  // EEPROM answers only in the top 1K of its 4K window
  assign hit_ee = eeprom_on && cpu_addr[15:12] == eeprom_base_position[7:4] &&
                  cpu_addr[11:10] == 2'b11; // RQ10
  // Swap puts large array at bottom, small at top
  assign hit_small = misc_mapping_control[RMD_SMALL_EN_BIT] &&
                     (swap ? cpu_addr >= RMD_FLASH_HIGH_LO
                           : (cpu_addr >= RMD_FLASH_LOW_LO && cpu_addr < RMD_FLASH_SPLIT)); // RQ13
  assign hit_large = misc_mapping_control[RMD_LARGE_EN_BIT] &&
                     (swap ? cpu_addr < RMD_FLASH_SPLIT : cpu_addr >= RMD_FLASH_SPLIT); // RQ12

  // Priority chain: only the highest claiming resource is selected
  always_comb begin
    if (!active) begin
      // Idle, or mapping shut down in wait
      next_target = RMD_TGT_NONE;
    end else if (hit_dbg) begin
      // Debug ROM beats everything while active
      next_target = RMD_TGT_DBG; // RQ3
    end else if (hit_regs) begin
      // Registers hide whatever lies beneath
      next_target = RMD_TGT_REGS; // RQ3
    end else if (hit_ram) begin
      // RAM bytes under registers stay unreachable
      next_target = RMD_TGT_RAM; // RQ3
    end else if (hit_ee) begin
      // EEPROM wins over flash
      next_target = RMD_TGT_EE; // RQ3
    end else if (hit_small) begin
      // Flash arrays never overlap each other
      next_target = RMD_TGT_SMALL; // RQ3
    end else if (hit_large) begin
      // Second flash array
      next_target = RMD_TGT_LARGE; // RQ3
    end else if (expanded) begin
      // Anything left goes off chip
      next_target = RMD_TGT_EXT; // RQ4
    end else begin
      // Single-chip holes select nothing
      next_target = RMD_TGT_NONE;
    end
  end

  // ---------------------------------------------------------------------------
  // Registered decode outputs
  // ---------------------------------------------------------------------------
  // External win qualifies every bus-shaping output
  logic ext_like;
  assign ext_like = next_target == RMD_TGT_EXT;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sel_target <= 7'h00;
      sel_follow_region <= 1'b0;
      bus_narrow <= 1'b0;
      stretch_cycles <= 2'h0;
      map_shutdown <= 1'b0;
    end else begin
      sel_target <= next_target;
      map_shutdown <= wait_mode && wait_control[0]; // RQ7
      // Follow region is external space below flash and RAM only if unclaimed
      sel_follow_region <= ext_like && hit_follow; // RQ15
      bus_narrow <= ext_like && hit_follow && rmd_is_wide(op_mode) &&
                    misc_mapping_control[RMD_NARROW_BIT]; // RQ14
      // Stretch only matters off chip; internal targets never wait
      if (ext_like && hit_follow) begin
        stretch_cycles <= misc_mapping_control[RMD_RF_STR_LSB +: 2]; // RQ16
      end else if (ext_like) begin
        stretch_cycles <= misc_mapping_control[RMD_EX_STR_LSB +: 2]; // RQ17
      end else begin
        stretch_cycles <= 2'h0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // E clock stretch hold
  // ---------------------------------------------------------------------------
  logic [1:0] stretch_left;

  // Loads only at an E boundary, so stretch spans whole
  // E periods; the address must stand until the count drains
  // Counts E periods to hold high; a limitation is one access at a time
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      stretch_left <= 2'h0;
      e_hold_high <= 1'b0;
    end else if (e_phase_end) begin
      if (stretch_left != 2'h0) begin
        // Mid-stretch: count down, drop on last period
        stretch_left <= stretch_left - 2'h1;
        e_hold_high <= (stretch_left != 2'h1); // RQ19
      end else begin
        // Idle: take the stretch of the access on the bus
        stretch_left <= stretch_cycles;
        e_hold_high <= stretch_cycles != 2'h0; // RQ19
      end
    end
  end

endmodule

`default_nettype wire

// ---- tb/rmd_decoder_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmd_decoder_monitor #(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] op_mode,
  input wire logic wait_mode,
  input wire logic background_debug,
  input wire logic cpu_valid,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic [6:0] sel_target,
  input wire logic sel_follow_region,
  input wire logic bus_narrow,
  input wire logic e_hold_high,
  input wire logic map_shutdown
);
  // ---
  // Bus and decode relations
  // ---
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Slave answers in the cycle after setup
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_tgt_onehot: assert property ($onehot0(sel_target))
    else $error("more than one target");
  a_idle_none: assert property (!cpu_valid |=> sel_target == 7'h00)
    else $error("target without request");
  a_dbg_top: assert property (cpu_valid && background_debug && !wait_mode &&
    cpu_addr[15:8] == 8'hff |=> sel_target == 7'h01) else $error("debug rom lost");
  a_sc_no_ext: assert property (!op_mode[0] |=> !sel_target[6])
    else $error("external target in single chip");
  a_follow_ext: assert property (sel_follow_region |-> sel_target[6])
    else $error("follow region not external");
  a_narrow_wide: assert property (bus_narrow |-> sel_follow_region && op_mode[1:0] == 2'h3)
    else $error("narrow path outside wide follow");
  a_hold_exp: assert property (e_hold_high |-> op_mode[0])
    else $error("stretch in single chip");
  a_shut_none: assert property (map_shutdown |-> sel_target == 7'h00 && $past(wait_mode))
    else $error("decode while shut down");
  c_narrow: cover property (bus_narrow);
  c_shut: cover property (map_shutdown);
  c_hold: cover property (e_hold_high);
endmodule
bind rmd_decoder rmd_decoder_monitor #(.ADDR_W(ADDR_W)) u_mon (.sys_clk, .nrst, .psel,
  .penable, .pready, .pslverr, .op_mode, .wait_mode, .background_debug, .cpu_valid,
  .cpu_addr, .sel_target, .sel_follow_region, .bus_narrow, .e_hold_high, .map_shutdown);
`default_nettype wire

// ---- tb/rmd_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmd_cpu_model #(
  parameter int E_DIV = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic req,
  input wire logic [15:0] req_addr,
  output logic cpu_valid,
  output logic [15:0] cpu_addr,
  output logic e_phase_end
);
  logic [15:0] last;
  logic [7:0] cnt;
  // Released bus shows the inverse, so no stale address can pass
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) last <= 16'h0;
    else if (req) last <= req_addr;
  end
  assign cpu_valid = req;
  assign cpu_addr = req ? req_addr : ~last;
  // One-cycle pulse at each E period end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) cnt <= 8'h0;
    else cnt <= (cnt == 8'(E_DIV - 1)) ? 8'h0 : cnt + 8'h1;
  end
  assign e_phase_end = (cnt == 8'(E_DIV - 1));
endmodule
`default_nettype wire

// ---- tb/tb_rmd_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_rmd_decoder;
  import rmd_pkg::*;
  logic sys_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h0, m [5], ra [5], mk [5];
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'hf299a191;
  logic [2:0] op_mode = RMD_MODE_SPC_WIDE;
  logic wait_mode = 1'h0, background_debug = 1'h0, req = 1'h0, pend = 1'h0, pready, pslverr;
  logic cpu_valid, e_phase_end, sel_follow_region, bus_narrow, e_hold_high, map_shutdown;
  logic [15:0] req_addr = 16'h0, cpu_addr, pa;
  logic [6:0] sel_target;
  logic [1:0] stretch_cycles;
  logic [4:0] wr1;
  int fail_count = 0, n_checks = 0;
  rmd_decoder u_rmd_decoder (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .op_mode, .wait_mode, .background_debug, .cpu_valid,
    .cpu_addr, .e_phase_end, .sel_target, .sel_follow_region, .bus_narrow, .stretch_cycles,
    .e_hold_high, .map_shutdown);
  rmd_cpu_model u_rmd_cpu_model (.sys_clk, .nrst, .req, .req_addr, .cpu_valid, .cpu_addr,
    .e_phase_end);
  always #5 sys_clk = ~sys_clk;
  // ---
  // Expectation and bus helpers
  // ---
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [6:0] tgt(input logic [15:0] a);
    logic f;
    f = m[3][7];
    if (wait_mode && m[4][0]) return RMD_TGT_NONE;
    if (background_debug && a >= RMD_DBG_ROM_LO) return RMD_TGT_DBG;
    if (a[15:9] == {m[1][7:3], 2'h0}) return RMD_TGT_REGS;
    if (a[15:11] == m[0][7:3]) return RMD_TGT_RAM;
    if ((m[2][0] || !op_mode[0]) && a[15:10] == {m[2][7:4], 2'h3}) return RMD_TGT_EE;
    if (m[3][1] && (f ? a >= RMD_FLASH_HIGH_LO : a >= RMD_FLASH_LOW_LO && a < RMD_FLASH_SPLIT))
      return RMD_TGT_SMALL;
    if (m[3][0] && (f ? a < RMD_FLASH_SPLIT : a >= RMD_FLASH_SPLIT)) return RMD_TGT_LARGE;
    return op_mode[0] ? RMD_TGT_EXT : RMD_TGT_NONE;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bounded wait on ready; a pending address rides on the release edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n == 16) fail_count++;
    if (n == 16) print_verdict();
    q = prdata[7:0];
    chk(|prdata[31:8], 1'h0);
    chk(pslverr, !(a inside {ra}));
    psel <= 1'h0;
    penable <= 1'h0;
    if (pend) begin
      req <= 1'h1;
      req_addr <= pa;
    end
    @(posedge sys_clk);
  endtask
  task automatic wreg(input int i, input logic [7:0] d);
    logic [7:0] q;
    apb(1'h1, ra[i], d, q);
    if (i == 4 ? !op_mode[2] : op_mode[2] && wr1[i]) begin
      if (i == 2 && op_mode[2]) m[2][0] = d[0];
    end else begin
      m[i] = d & mk[i];
    end
    wr1[i] = 1'h1;
  endtask
  task automatic rdc(input int i);
    logic [7:0] q;
    apb(1'h0, ra[i], 8'h0, q);
    chk(q, (i == 2 && !op_mode[0]) ? m[2] | 8'h01 : m[i]);
  endtask
  task automatic look(input logic [15:0] a);
    logic [6:0] t;
    logic f;
    @(posedge sys_clk);
    t = tgt(a);
    f = t == RMD_TGT_EXT && a[15:9] == {m[1][7:3], 2'h1};
    chk(sel_target, t);
    if (t == RMD_TGT_EXT) begin
      chk(sel_follow_region, f);
      chk(stretch_cycles, f ? m[3][5:4] : m[3][3:2]);
      chk(bus_narrow, f && m[3][6] && op_mode[1:0] == 2'h3);
    end
  endtask
  task automatic dec(input logic [15:0] a);
    req <= 1'h1;
    req_addr <= a;
    @(posedge sys_clk);
    req <= 1'h0;
    look(a);
  endtask
  task automatic hold(input logic [15:0] a, input logic e);
    logic h;
    h = 1'h0;
    req <= 1'h1;
    req_addr <= a;
    repeat (10) begin
      @(posedge sys_clk);
      h = h | e_hold_high;
    end
    req <= 1'h0;
    chk(h, e);
    repeat (20) @(posedge sys_clk);
    chk(e_hold_high, 1'h0);
  endtask
  task automatic rst(input logic [2:0] md);
    nrst <= 1'h0;
    req <= 1'h0;
    op_mode <= md;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'h1;
    repeat (3) @(posedge sys_clk);
    m = '{RMD_RST_RAM_BASE, RMD_RST_REG_BASE, RMD_RST_EE_BASE,
      md[0] ? RMD_RST_MISC_EXP : RMD_RST_MISC_SC, RMD_RST_WAIT_CTRL};
    wr1 = 5'h0;
  endtask
  // ---
  // Main sequence
  // ---
  initial begin
    logic [7:0] q;
    int i;
    ra = '{RMD_ADDR_RAM_BASE, RMD_ADDR_REG_BASE, RMD_ADDR_EE_BASE, RMD_ADDR_MISC,
      RMD_ADDR_WAIT_CTRL};
    mk = '{RMD_MASK_RAM_BASE, RMD_MASK_REG_BASE, RMD_MASK_EE_BASE, 8'hff, RMD_MASK_WAIT_CTRL};
    rst(RMD_MODE_SPC_WIDE);
    for (i = 0; i < 5; i++) rdc(i);
    apb(1'h0, 8'h20, 8'h0, q);
    $display("test reset values done");
    // Random map with half the addresses steered into the follow, RAM, EEPROM and register windows
    for (i = 0; i < 400; i++) begin
      seed = xs(seed);
      pa = seed[31:16];
      case (seed[2:0])
        3'h0: pa[15:9] = {m[1][7:3], 2'h1};
        3'h1: pa[15:11] = m[0][7:3];
        3'h2: pa[15:10] = {m[2][7:4], 2'h3};
        3'h3: pa[15:11] = m[1][7:3];
        default: ;
      endcase
      if (seed[4:3] == 2'h0) begin
        pend = 1'h1;
        wreg(seed[7:5] % 5, seed[15:8]);
        pend = 1'h0;
        look(pa);
        rdc(seed[7:5] % 5);
      end else begin
        background_debug <= seed[5];
        dec(pa);
      end
    end
    $display("test random map done");
    rst(RMD_MODE_NRM_WIDE);
    wreg(1, 8'h08);
    wreg(1, 8'h10);
    rdc(1);
    dec(16'h0800);
    dec(16'h0100);
    dec(16'h0a00);
    dec(16'h4000);
    hold(16'h4000, 1'h1);
    wreg(3, 8'h70);
    dec(16'h0bfe);
    wreg(4, 8'h01);
    wait_mode <= 1'h1;
    dec(16'h0800);
    chk(map_shutdown, 1'h1);
    wait_mode <= 1'h0;
    $display("test normal mode done");
    rst(RMD_MODE_NRM_SC);
    for (i = 0; i < 5; i++) rdc(i);
    wreg(2, 8'h30);
    rdc(2);
    dec(16'h3c00);
    dec(16'h0a00);
    hold(16'h4000, 1'h0);
    $display("test single chip done");
    print_verdict();
  end
endmodule
`default_nettype wire
